// File: design/rtc_alarm2_timer_ram_pwrctl.sv
// alarm 2 compare, countdown timer, user ram and power control registers
module rtc_alarm2_timer_ram_pwrctl #(
  parameter int DEPTH = rtc_alarm2_pkg::RAM_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire rtc_alarm2_pkg::reg_req_t i_req,
  input wire rtc_alarm2_pkg::time_now_t i_time_now,
  input wire logic i_minute_rollover,
  input wire logic i_alarm2_irq_enable,
  input wire logic i_alarm2_flag_clear,
  input wire logic i_timer_enable,
  input wire logic i_timer_repeat,
  input wire logic i_timer_tick,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_alarm2_flag,
  output logic o_alarm2_irq,
  output logic o_timer_zero,
  output logic o_timer_reload,
  output rtc_alarm2_pkg::supply_t o_supply,
  output logic [1:0] o_mode
);
  rtc_alarm2_pkg::alarm2_regs_t alarm2, next_alarm2;
  logic [7:0] count, next_count;
  logic [7:0] reload, next_reload;
  logic [7:0] power, next_power;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic flag, next_flag;
  logic irq, next_irq;
  logic tzero, next_tzero;
  logic treload, next_treload;
  rtc_alarm2_pkg::supply_t supply, next_supply;
  logic [1:0] mode, next_mode;
  logic [7:0] ram [DEPTH];
  logic ram_hit;
  logic [5:0] ram_idx;
  logic match;

  function automatic logic at(input rtc_alarm2_pkg::reg_req_t r,
                              input logic [6:0] a);
    at = (r.addr == a);
  endfunction

  function automatic logic wr_at(input rtc_alarm2_pkg::reg_req_t r,
                                 input logic [6:0] a);
    wr_at = r.write && at(r, a);
  endfunction

  // masked compare; bits outside the field are don't-care
  function automatic logic same(input logic [7:0] a, input logic [7:0] b,
                                input logic [7:0] m);
    same = ((a ^ b) & m) == '0;
  endfunction

  always_comb begin
    ram_hit = (i_req.addr >= rtc_alarm2_pkg::ADDR_RAM_FIRST) &&
              (i_req.addr <= rtc_alarm2_pkg::ADDR_RAM_LAST);
    ram_idx = 6'(i_req.addr - rtc_alarm2_pkg::ADDR_RAM_FIRST);
  end

  always_comb begin
    match = 1'b1;
    if (!alarm2.minutes[rtc_alarm2_pkg::BIT_MASK]) begin
      match = match && same(alarm2.minutes, i_time_now.minutes,
                            rtc_alarm2_pkg::MINUTES_FIELD);
    end
    if (!alarm2.hours[rtc_alarm2_pkg::BIT_MASK]) begin
      match = match && same(alarm2.hours, i_time_now.hours,
                            rtc_alarm2_pkg::HOURS_FIELD);
    end
    if (!alarm2.day_or_date[rtc_alarm2_pkg::BIT_MASK]) begin
      if (alarm2.day_or_date[rtc_alarm2_pkg::BIT_WEEKDAY]) begin
        match = match && same(alarm2.day_or_date, i_time_now.weekday,
                              rtc_alarm2_pkg::DAY_DATE_FIELD);
      end else begin
        match = match && same(alarm2.day_or_date, i_time_now.date,
                              rtc_alarm2_pkg::DAY_DATE_FIELD);
      end
    end
  end

  always_comb begin
    next_alarm2 = alarm2;
    next_reload = reload;
    next_power = power;
    if (wr_at(i_req, rtc_alarm2_pkg::ADDR_ALARM2_MINUTES)) begin
      next_alarm2.minutes = i_req.wdata;
    end
    if (wr_at(i_req, rtc_alarm2_pkg::ADDR_ALARM2_HOURS)) begin
      next_alarm2.hours = i_req.wdata & rtc_alarm2_pkg::HOURS_WRITE_MASK;
    end
    if (wr_at(i_req, rtc_alarm2_pkg::ADDR_ALARM2_DAY_OR_DATE)) begin
      next_alarm2.day_or_date = i_req.wdata;
    end
    if (wr_at(i_req, rtc_alarm2_pkg::ADDR_COUNTDOWN_RELOAD)) begin
      next_reload = i_req.wdata;
    end
    if (wr_at(i_req, rtc_alarm2_pkg::ADDR_POWER_SUPPLY_CONTROL)) begin
      next_power = i_req.wdata & rtc_alarm2_pkg::POWER_WRITE_MASK;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alarm2 <= '0;
      reload <= rtc_alarm2_pkg::RESET_BYTE;
      power <= rtc_alarm2_pkg::RESET_BYTE;
    end else begin
      alarm2 <= next_alarm2;
      reload <= next_reload;
      power <= next_power;
    end
  end

  always_comb begin
    next_count = count;
    next_treload = 1'b0;
    if (!i_timer_enable) begin
      next_count = reload;
    end else if (i_timer_tick) begin
      if (count == rtc_alarm2_pkg::COUNT_ZERO) begin
        if (i_timer_repeat) begin
          next_count = reload;
          next_treload = 1'b1;
        end
      end else begin
        next_count = count - rtc_alarm2_pkg::COUNT_ONE;
      end
    end
    next_tzero = i_timer_enable && (next_count == rtc_alarm2_pkg::COUNT_ZERO);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= rtc_alarm2_pkg::COUNT_ZERO;
      tzero <= 1'b0;
      treload <= 1'b0;
    end else begin
      count <= next_count;
      tzero <= next_tzero;
      treload <= next_treload;
    end
  end

  // unmapped reads still answer, with a zero byte
  always_comb begin
    next_rvalid = i_req.read;
    next_rdata = rtc_alarm2_pkg::RESET_BYTE;
    if (i_req.read) begin
      if (at(i_req, rtc_alarm2_pkg::ADDR_ALARM2_MINUTES)) begin
        next_rdata = alarm2.minutes;
      end else if (at(i_req, rtc_alarm2_pkg::ADDR_ALARM2_HOURS)) begin
        next_rdata = alarm2.hours;
      end else if (at(i_req, rtc_alarm2_pkg::ADDR_ALARM2_DAY_OR_DATE)) begin
        next_rdata = alarm2.day_or_date;
      end else if (at(i_req, rtc_alarm2_pkg::ADDR_COUNTDOWN_CURRENT)) begin
        next_rdata = count;
      end else if (at(i_req, rtc_alarm2_pkg::ADDR_COUNTDOWN_RELOAD)) begin
        next_rdata = reload;
      end else if (ram_hit) begin
        next_rdata = ram[ram_idx];
      end else if (at(i_req, rtc_alarm2_pkg::ADDR_POWER_SUPPLY_CONTROL)) begin
        next_rdata = power;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata <= rtc_alarm2_pkg::RESET_BYTE;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  always_comb begin
    next_flag = flag;
    if (i_alarm2_flag_clear) begin
      next_flag = 1'b0;
    end
    if (i_minute_rollover && match) begin
      next_flag = 1'b1;
    end
    next_irq = next_flag && i_alarm2_irq_enable;
  end

  // irq registered with the flag, so both move on the same edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      flag <= next_flag;
      irq <= next_irq;
    end
  end

  always_comb begin
    if (!next_power[rtc_alarm2_pkg::BIT_MANUAL_SELECT]) begin
      next_supply = rtc_alarm2_pkg::SUPPLY_AUTO;
    end else if (next_power[rtc_alarm2_pkg::BIT_SUPPLY_CHOICE]) begin
      next_supply = rtc_alarm2_pkg::SUPPLY_BACKUP;
    end else begin
      next_supply = rtc_alarm2_pkg::SUPPLY_MAIN;
    end
    next_mode = next_power[rtc_alarm2_pkg::MODE_MSB:0];
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      supply <= rtc_alarm2_pkg::SUPPLY_AUTO;
      mode <= rtc_alarm2_pkg::MODE_COMPARATOR;
    end else begin
      supply <= next_supply;
      mode <= next_mode;
    end
  end

  // ram holds no reset; power-on content undefined
  always_ff @(posedge i_clk_sys) begin
    if (i_req.write && ram_hit) begin
      ram[ram_idx] <= i_req.wdata;
    end
  end

  assign o_rdata = rdata;
  assign o_rvalid = rvalid;
  assign o_alarm2_flag = flag;
  assign o_alarm2_irq = irq;
  assign o_timer_zero = tzero;
  assign o_timer_reload = treload;
  assign o_supply = supply;
  assign o_mode = mode;
endmodule

// File: include/rtc_alarm2_pkg.sv
// constants and types for the alarm 2, timer, ram and power block
package rtc_alarm2_pkg;
  localparam logic [6:0] ADDR_ALARM2_MINUTES = 7'h11;
  localparam logic [6:0] ADDR_ALARM2_HOURS = 7'h12;
  localparam logic [6:0] ADDR_ALARM2_DAY_OR_DATE = 7'h13;
  localparam logic [6:0] ADDR_COUNTDOWN_CURRENT = 7'h14;
  localparam logic [6:0] ADDR_COUNTDOWN_RELOAD = 7'h15;
  localparam logic [6:0] ADDR_RAM_FIRST = 7'h16;
  localparam logic [6:0] ADDR_RAM_LAST = 7'h55;
  localparam logic [6:0] ADDR_POWER_SUPPLY_CONTROL = 7'h56;
  localparam int RAM_DEPTH = 64;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] HOURS_WRITE_MASK = 8'hbf;
  localparam logic [7:0] POWER_WRITE_MASK = 8'h0f;
  localparam int BIT_MASK = 7;
  localparam int BIT_WEEKDAY = 6;
  localparam int BIT_SUPPLY_CHOICE = 3;
  localparam int BIT_MANUAL_SELECT = 2;
  localparam logic [1:0] MODE_COMPARATOR = 2'h0;
  localparam logic [1:0] MODE_POWER_MGMT = 2'h1;
  localparam logic [7:0] MINUTES_FIELD = 8'h7f;
  localparam logic [7:0] HOURS_FIELD = 8'h3f;
  localparam logic [7:0] DAY_DATE_FIELD = 8'h3f;
  localparam int MODE_MSB = 1;
  typedef enum logic [1:0] {
    SUPPLY_AUTO = 2'b00,
    SUPPLY_MAIN = 2'b01,
    SUPPLY_BACKUP = 2'b10
  } supply_t;
  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] day_or_date;
  } alarm2_regs_t;
  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] date;
    logic [7:0] weekday;
  } time_now_t;
  typedef struct packed {
    logic write;
    logic read;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// File: sim/rtc_alarm2_sva.sv
// assertion checker for the alarm 2, timer and power block
module rtc_alarm2_sva #(
  parameter int DEPTH = 64
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire rtc_alarm2_pkg::reg_req_t i_req,
  input wire logic i_minute_rollover,
  input wire logic i_alarm2_irq_enable,
  input wire logic i_alarm2_flag_clear,
  input wire logic i_timer_enable,
  input wire logic i_timer_repeat,
  input wire logic o_rvalid,
  input wire logic o_alarm2_flag,
  input wire logic o_alarm2_irq,
  input wire logic o_timer_reload,
  input wire rtc_alarm2_pkg::supply_t o_supply,
  input wire logic [1:0] o_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pw;
  assign pw = i_req.write &&
    i_req.addr == rtc_alarm2_pkg::ADDR_POWER_SUPPLY_CONTROL;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_rd; o_rvalid == $past(i_req.read); endproperty
  a_rd: assert property (p_rd) else $error("no rvalid");
  property p_auto; pw && !i_req.wdata[2] |=> o_supply == 2'b00; endproperty
  a_auto: assert property (p_auto) else $error("not auto");
  property p_man; pw && i_req.wdata[2] |=>
    o_supply == {$past(i_req.wdata[3]), !$past(i_req.wdata[3])}; endproperty
  a_man: assert property (p_man) else $error("bad supply");
  property p_mode; pw |=> o_mode == $past(i_req.wdata[1:0]); endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_irq;
    o_alarm2_irq == (o_alarm2_flag && $past(i_alarm2_irq_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("bad irq");
  property p_rise; $rose(o_alarm2_flag) |-> $past(i_minute_rollover);
  endproperty
  a_rise: assert property (p_rise) else $error("stray flag");
  property p_hold; o_alarm2_flag && !i_alarm2_flag_clear |=> o_alarm2_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_rel;
    o_timer_reload |-> $past(i_timer_repeat) && $past(i_timer_enable);
  endproperty
  a_rel: assert property (p_rel) else $error("bad reload");
endmodule

// File: sim/rtc_host_model.sv
// register host issuing single byte requests
module rtc_host_model (
  input wire logic i_clk_sys,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  output rtc_alarm2_pkg::reg_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  task automatic xfer(input logic w, input logic [6:0] a,
    input logic [7:0] d, output logic [7:0] q);
    if (a == 7'h12) d[6] = 1'b0;
    if (a == 7'h56) d[1] = 1'b0;
    @(posedge i_clk_sys);
    #1 o_req = {w, !w, a, d};
    @(posedge i_clk_sys);
    #1 q = (i_rvalid === w) ? 8'hxx : i_rdata;
    // released lines never keep the last value
    o_req = {2'b00, ~a, ~d};
  endtask
endmodule

// File: sim/tb_rtc_alarm2_timer_ram_pwrctl.sv
// self-checking bench for the alarm 2, timer, ram and power block
module tb_rtc_alarm2_timer_ram_pwrctl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, roll = 0, ien = 0, fclr = 0, ten = 0;
  logic trep = 0, tick = 0, rvalid, flag, irq, tz, trl;
  logic [7:0] rdata, q, v;
  logic [1:0] mode;
  logic [31:0] lf = 32'h0000_0e80;
  int error_cnt = 0, n_checks = 0, cyc = 0, mdl[128];
  rtc_alarm2_pkg::reg_req_t req;
  rtc_alarm2_pkg::supply_t sup;
  rtc_alarm2_pkg::time_now_t now = 32'h2513_1703;
  logic [31:0] ac[9] = '{32'h8080_8001, 32'h2580_8001, 32'h2680_8000,
    32'h2513_8001, 32'h2512_8000, 32'h2513_1701, 32'h2513_0300,
    32'h2513_4301, 32'h2513_5700};
  rtc_alarm2_timer_ram_pwrctl dut_u (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_req(req), .i_time_now(now), .i_minute_rollover(roll),
    .i_alarm2_irq_enable(ien), .i_alarm2_flag_clear(fclr),
    .i_timer_enable(ten), .i_timer_repeat(trep), .i_timer_tick(tick),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_alarm2_flag(flag),
    .o_alarm2_irq(irq), .o_timer_zero(tz), .o_timer_reload(trl),
    .o_supply(sup), .o_mode(mode));
  rtc_host_model host_u (.i_clk_sys(clk), .i_rvalid(rvalid),
    .i_rdata(rdata), .o_req(req));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, q);
    if (a == 7'h12) d[6] = 1'b0;
    if (a == 7'h56) d = d & 8'h0d;
    if (a > 7'h10 && a < 7'h57 && a != 7'h14) mdl[a] = d;
  endtask
  task automatic rc(input logic [6:0] a);
    // idle timer follows its reload value
    if (!ten) mdl[20] = mdl[21];
    host_u.xfer(1'b0, a, 8'h00, q);
    chk(q, 8'(mdl[a]));
  endtask
  task automatic tk();
    pulse(tick);
    chk(8'(trl), 8'(trep && mdl[20] == 0));
    mdl[20] = mdl[20] ? mdl[20] - 1 : (trep ? mdl[21] : 0);
    chk(8'(tz), 8'(mdl[20] == 0));
  endtask
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      chk(8'h01, 8'h00);
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(8'(sup), 8'h00);
    for (int a = 17; a < 22; a++) rc(7'(a));
    rc(7'h56);
    // random fill, ram and a write to the read-only count
    for (int a = 17; a < 88; a++) begin
      lf = nx(lf);
      wr(7'(a), lf[7:0]);
    end
    for (int a = 17; a < 88; a++) rc(7'(a));
    for (int i = 0; i < 8; i++) begin
      v = 8'({i[2:1], 1'b0, i[0]});
      wr(7'h56, v);
      chk(8'(sup), v[2] ? (v[3] ? 8'h02 : 8'h01) : 8'h00);
      chk(8'(mode), 8'(v[0]));
    end
    foreach (ac[i]) begin
      for (int k = 0; k < 3; k++) wr(7'h11 + 7'(k), ac[i][31-8*k -: 8]);
      lf = nx(lf);
      ien = lf[0];
      pulse(roll);
      chk(8'(flag), ac[i][7:0]);
      chk(8'(irq), 8'(ac[i][0] & ien));
      pulse(fclr);
      chk(8'(flag), 8'h00);
    end
    // match and clear in one cycle: the set must win
    wr(7'h11, 8'h80);
    wr(7'h13, 8'h80);
    @(posedge clk);
    #1 roll = 1'b1;
    fclr = 1'b1;
    @(posedge clk);
    #1 roll = 1'b0;
    fclr = 1'b0;
    chk(8'(flag), 8'h01);
    pulse(fclr);
    chk(8'(flag), 8'h00);
    wr(7'h15, 8'h03);
    rc(7'h14);
    ten = 1'b1;
    repeat (4) tk();
    trep = 1'b1;
    repeat (5) tk();
    rc(7'h14);
    wrap_up();
  end
endmodule
bind rtc_alarm2_timer_ram_pwrctl rtc_alarm2_sva #(.DEPTH(DEPTH)) chk_u (
  .i_clk_sys, .i_rst_n, .i_req, .i_minute_rollover, .i_alarm2_irq_enable,
  .i_alarm2_flag_clear, .i_timer_enable, .i_timer_repeat, .o_rvalid,
  .o_alarm2_flag, .o_alarm2_irq, .o_timer_reload, .o_supply, .o_mode);
